// File: dlr_map.svh
// Constants for the diagnostic line role controller.
`ifndef DLR_MAP_SVH
`define DLR_MAP_SVH
`define DLR_CLK_HZ        100000000
`define DLR_SLOW_BAUD     5
`define DLR_SLOW_BIT_CYC  (`DLR_CLK_HZ / `DLR_SLOW_BAUD)
`define DLR_ADDR_STD      8'h33
`define DLR_SYNC_BYTE     8'h55
`define DLR_KEY1          8'h94
`define DLR_KEY2          8'h94
`define DLR_FRAME_BITS    4'h9
`define DLR_CNT_W         32
`endif

// File: dlr_pkg.sv
// Types shared by the diagnostic line role controller.
`default_nettype none
package dlr_pkg;
  typedef enum logic [3:0]
  {
    DLR_IDLE     = 4'h0,
    DLR_ADDR     = 4'h1,
    DLR_SYNC     = 4'h2,
    DLR_KEY1     = 4'h3,
    DLR_KEY2     = 4'h4,
    DLR_WAIT_INV = 4'h5,
    DLR_SEND_INV = 4'h6,
    DLR_ONLINE   = 4'h7
  } dlr_state_t;
endpackage
`default_nettype wire

// File: dlr_tx.sv
// Serial frame transmitter that drives the bidirectional line low only while sending.
`timescale 1ns/1ps
`default_nettype none
`include "dlr_map.svh"
module dlr_tx
(
  input  wire logic        ref_clk_in,
  input  wire logic        srst_in,
  input  wire logic        start_in,
  input  wire logic [7:0]  data_in,
  input  wire logic [31:0] bit_cyc_in,
  output var  logic        line_out,
  output var  logic        busy_out
);
  typedef struct packed
  {
    logic        busy;
    logic        line;
    logic [9:0]  shf;
    logic [3:0]  bits;
    logic [31:0] cnt;
  } dlr_tx_st_t;
  dlr_tx_st_t s_q;
  dlr_tx_st_t s_d;

  // Shift out start bit, eight data bits LSB first, then stop bit.
  always_comb
  begin
    s_d = s_q;
    if (!s_q.busy)
    begin
      s_d.line = 1'b1;
      if (start_in)
      begin
        s_d.busy = 1'b1;
        s_d.shf  = {1'b1, data_in, 1'b0};
        s_d.line = 1'b0;
        s_d.bits = 4'h0;
        s_d.cnt  = 32'h0;
      end
    end
    else if (s_q.cnt + 32'h1 >= bit_cyc_in)
    begin
      s_d.cnt = 32'h0;
      if (s_q.bits == `DLR_FRAME_BITS)
      begin
        s_d.busy = 1'b0;
        s_d.line = 1'b1;
      end
      else
      begin
        s_d.bits = s_q.bits + 4'h1;
        s_d.shf  = {1'b1, s_q.shf[9:1]};
        s_d.line = s_q.shf[1];
      end
    end
    else
    begin
      s_d.cnt = s_q.cnt + 32'h1;
    end
  end

  // State register.
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      s_q <= '{busy: 1'b0, line: 1'b1, shf: 10'h3ff, bits: 4'h0, cnt: 32'h0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign line_out = s_q.line;
  assign busy_out = s_q.busy;
endmodule
`default_nettype wire

// File: dlr_ctrl.sv
// On-board control unit end of the diagnostic line pair: role, direction and wake-up handling.
// Function
// - Works with data line alone or both lines.
// - Data line bidirectional, driven in phases.
// - After address, init continues on data line.
// - Then requests and responses use data line.
// - Other units' data never starts our session.
// - Send sync only in our assigned slot.
// - Prevent collisions for sync and responses.
// - Unit answers inverted address.
`timescale 1ns/1ps
`default_nettype none
`include "dlr_map.svh"
module dlr_ctrl
#(
  parameter logic [31:0] SLOW_BIT_CYC = `DLR_SLOW_BIT_CYC,
  parameter logic [31:0] SLOT_CYC     = 32'h0
)
(
  input  wire logic              ref_clk_in,
  input  wire logic              srst_in,
  input  wire logic              two_wire_in,
  input  wire logic [7:0]        my_addr_in,
  input  wire logic [31:0]       fast_bit_cyc_in,
  input  wire logic              kline_in,
  input  wire logic              lline_in,
  input  wire logic              other_tx_in,
  input  wire logic              resp_req_in,
  input  wire logic [7:0]        resp_data_in,
  output var  logic              kline_out,
  output var  logic              kline_oe_out,
  output var  logic              online_out,
  output var  logic              resp_done_out,
  output var  dlr_pkg::dlr_state_t state_out
);
  import dlr_pkg::*;

  typedef struct packed
  {
    dlr_state_t  st;
    logic [31:0] cnt;
    logic [3:0]  bits;
    logic [7:0]  shf;
    logic        rx_act;
    logic        kprev;
    logic        tx_go;
    logic [7:0]  tx_data;
    logic        use_fast;
    logic        oe;
    logic        kout;
    logic        online;
    logic        done;
    logic        wait_tx;
  } dlr_st_t;
  dlr_st_t s_q;
  dlr_st_t s_d;

  logic tx_line;
  logic tx_busy;

  // Frame transmitter shared by header, handshake and responses.
  dlr_tx u_tx
  (
    .ref_clk_in (ref_clk_in),
    .srst_in    (srst_in),
    .start_in   (s_q.tx_go),
    .data_in    (s_q.tx_data),
    .bit_cyc_in (s_q.use_fast ? fast_bit_cyc_in : SLOW_BIT_CYC),
    .line_out   (tx_line),
    .busy_out   (tx_busy)
  );

  // Odd-parity form of a seven bit key word.
  function automatic logic [7:0] key_parity(input logic [7:0] k);
    key_parity = {~^k[6:0], k[6:0]};
  endfunction

  // Address sample: reads high only when both lines are high in two-wire wiring.
  logic addr_bit;
  assign addr_bit = two_wire_in ? (kline_in & lline_in) : kline_in;

  // Main sequencer.
  always_comb
  begin
    s_d       = s_q;
    s_d.tx_go = 1'b0;
    s_d.done  = 1'b0;
    s_d.kprev = addr_bit;
    case (s_q.st)
      DLR_IDLE:
      begin
        if (s_q.kprev && !addr_bit && !other_tx_in)
        begin
          s_d.st     = DLR_ADDR;
          s_d.cnt    = 32'h0;
          s_d.bits   = 4'h0;
          s_d.rx_act = 1'b1;
        end
      end
      DLR_ADDR:
      begin
        if (s_q.cnt + 32'h1 >= ((s_q.bits == 4'h0) ? (SLOW_BIT_CYC >> 1) : SLOW_BIT_CYC))
        begin
          s_d.cnt  = 32'h0;
          s_d.bits = s_q.bits + 4'h1;
          if (s_q.bits == 4'h0 && addr_bit)
          begin
            s_d.st = DLR_IDLE;
          end
          else if (s_q.bits >= 4'h1 && s_q.bits <= 4'h8)
          begin
            s_d.shf = {addr_bit, s_q.shf[7:1]};
          end
          else if (s_q.bits == `DLR_FRAME_BITS)
          begin
            if (addr_bit && s_q.shf == my_addr_in)
            begin
              s_d.st  = DLR_SYNC;
              s_d.cnt = 32'h0;
            end
            else
            begin
              s_d.st = DLR_IDLE;
            end
          end
        end
        else
        begin
          s_d.cnt = s_q.cnt + 32'h1;
        end
      end
      DLR_SYNC:
      begin
        // Wait own slot, then send sync
        if (s_q.cnt >= SLOT_CYC && !tx_busy && !other_tx_in)
        begin
          s_d.tx_go    = 1'b1;
          s_d.tx_data  = `DLR_SYNC_BYTE;
          s_d.use_fast = 1'b1;
          s_d.st       = DLR_KEY1;
          s_d.wait_tx  = 1'b1;
        end
        else
        begin
          s_d.cnt = s_q.cnt + 32'h1;
        end
      end
      DLR_KEY1, DLR_KEY2:
      begin
        if (s_q.wait_tx)
        begin
          s_d.wait_tx = 1'b0;
        end
        else if (!tx_busy)
        begin
          s_d.tx_go   = 1'b1;
          s_d.wait_tx = 1'b1;
          s_d.tx_data = key_parity((s_q.st == DLR_KEY1) ? `DLR_KEY1 : `DLR_KEY2);
          s_d.st      = (s_q.st == DLR_KEY1) ? DLR_KEY2 : DLR_WAIT_INV;
        end
      end
      DLR_WAIT_INV:
      begin
        if (s_q.wait_tx)
        begin
          s_d.wait_tx = tx_busy | s_q.tx_go;
          s_d.bits    = 4'h0;
          s_d.rx_act  = 1'b0;
        end
        else if (!s_q.rx_act)
        begin
          if (s_q.kprev && !kline_in)
          begin
            s_d.rx_act = 1'b1;
            s_d.cnt    = 32'h0;
            s_d.bits   = 4'h0;
          end
        end
        else if (s_q.cnt + 32'h1 >= ((s_q.bits == 4'h0) ? (fast_bit_cyc_in >> 1) : fast_bit_cyc_in))
        begin
          s_d.cnt  = 32'h0;
          s_d.bits = s_q.bits + 4'h1;
          if (s_q.bits >= 4'h1 && s_q.bits <= 4'h8)
          begin
            s_d.shf = {kline_in, s_q.shf[7:1]};
          end
          else if (s_q.bits == `DLR_FRAME_BITS)
          begin
            s_d.rx_act = 1'b0;
            s_d.st     = (s_q.shf == ~key_parity(`DLR_KEY2)) ? DLR_SEND_INV : DLR_IDLE;
          end
        end
        else
        begin
          s_d.cnt = s_q.cnt + 32'h1;
        end
      end
      DLR_SEND_INV:
      begin
        s_d.tx_go   = 1'b1;
        s_d.tx_data = ~my_addr_in;
        s_d.st      = DLR_ONLINE;
        s_d.wait_tx = 1'b1;
        s_d.online  = 1'b1;
      end
      DLR_ONLINE:
      begin
        if (s_q.wait_tx)
        begin
          s_d.wait_tx = tx_busy | s_q.tx_go;
          s_d.done    = ~(tx_busy | s_q.tx_go);
        end
        else if (resp_req_in && !other_tx_in)
        begin
          s_d.tx_go   = 1'b1;
          s_d.tx_data = resp_data_in;
          s_d.wait_tx = 1'b1;
        end
      end
      default:
      begin
        s_d.st = DLR_IDLE;
      end
    endcase
    s_d.oe   = tx_busy & ~tx_line;
    s_d.kout = tx_busy ? tx_line : 1'b1;
  end

  // State register.
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      s_q <= '{st: DLR_IDLE, cnt: 32'h0, bits: 4'h0, shf: 8'h00, rx_act: 1'b0, kprev: 1'b1,
               tx_go: 1'b0, tx_data: 8'hff, use_fast: 1'b0, oe: 1'b0, kout: 1'b1,
               online: 1'b0, done: 1'b0, wait_tx: 1'b0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign kline_out     = s_q.kout;
  assign kline_oe_out  = s_q.oe;
  assign online_out    = s_q.online;
  assign resp_done_out = s_q.done;
  assign state_out     = s_q.st;

  property p_release;
    @(posedge ref_clk_in) disable iff (srst_in) !kline_oe_out |-> kline_out;
  endproperty
  a_release: assert property (p_release) else $error("line not released high");

  property p_drive_busy;
    @(posedge ref_clk_in) disable iff (srst_in) kline_oe_out |-> $past(tx_busy);
  endproperty
  a_drive_busy: assert property (p_drive_busy) else $error("drive without frame");

  // Other unit traffic never starts a session.
  property p_no_cross;
    @(posedge ref_clk_in) disable iff (srst_in)
      (s_q.st == DLR_IDLE && other_tx_in) |=> s_q.st == DLR_IDLE;
  endproperty
  a_no_cross: assert property (p_no_cross) else $error("cross initialisation");

  // No sync or response frame starts while another unit sends.
  property p_no_collide;
    @(posedge ref_clk_in) disable iff (srst_in)
      (other_tx_in && (s_q.st == DLR_SYNC || s_q.st == DLR_ONLINE) && !s_q.wait_tx) |=> !s_q.tx_go;
  endproperty
  a_no_collide: assert property (p_no_collide) else $error("simultaneous reply");

  property p_inv_addr;
    @(posedge ref_clk_in) disable iff (srst_in)
      s_q.st == DLR_SEND_INV |=> (s_q.tx_go && s_q.tx_data == ~my_addr_in && s_q.st == DLR_ONLINE);
  endproperty
  a_inv_addr: assert property (p_inv_addr) else $error("no inverted address");

  property p_online;
    @(posedge ref_clk_in) disable iff (srst_in) s_q.st == DLR_ONLINE |=> online_out;
  endproperty
  a_online: assert property (p_online) else $error("online lost");

  // Sync frame starts at fast rate.
  property p_sync;
    @(posedge ref_clk_in) disable iff (srst_in)
      $rose(s_q.st == DLR_KEY1) |-> (s_q.tx_data == `DLR_SYNC_BYTE && s_q.use_fast);
  endproperty
  a_sync: assert property (p_sync) else $error("sync byte wrong");

  property p_idle_quiet;
    @(posedge ref_clk_in) disable iff (srst_in) (s_q.st == DLR_ADDR) [*2] |-> !kline_oe_out;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("drive during address");

  c_addr: cover property (@(posedge ref_clk_in) disable iff (srst_in) s_q.st == DLR_SYNC);
  c_online: cover property (@(posedge ref_clk_in) disable iff (srst_in) $rose(online_out));
  c_resp: cover property (@(posedge ref_clk_in) disable iff (srst_in) resp_done_out);
endmodule
`default_nettype wire

// File: dlr_tester.sv
// Behavioural diagnostic tester that drives the data and wake-up lines.
`timescale 1ns/1ps
`default_nettype none
module dlr_tester
(
  input  wire logic ref_clk_in,
  input  wire logic kline_in,
  output var  logic kline_out,
  output var  logic lline_out
);
  // Both lines start released and idle at the high level.
  // Wake-up idles high
  initial
  begin
    kline_out = 1'b1;
    lline_out = 1'b1;
  end

  // Sends one frame; lmode 1 copies it onto the wake-up line, 2 holds that line low.
  // The task returns in the middle of the stop bit so that a prompt answer is not missed.
  // Frame on data line, and on wake-up line in lmode 1
  task automatic send(input logic [7:0] b, input int cyc, input int lmode);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(negedge ref_clk_in);
      kline_out = f[i];
      lline_out = (lmode == 1) ? f[i] : (lmode == 0);
      repeat ((i == 9) ? cyc / 2 : cyc - 1) @(negedge ref_clk_in);
    end
    lline_out = 1'b1;
  endtask

  // Receives one frame from the data line; a timeout or a bad stop bit gives unknown data.
  // The line is sampled on falling edges, where the unit's registered drive has settled.
  // Tester listens on data line
  task automatic recv(input int cyc, output logic [7:0] b);
    int n;
    b = 8'hxx;
    n = 0;
    while (kline_in !== 1'b0 && n < 3000)
    begin
      @(negedge ref_clk_in);
      n++;
    end
    if (n < 3000)
    begin
      repeat (cyc / 2) @(negedge ref_clk_in);
      for (int i = 0; i < 8; i++)
      begin
        repeat (cyc) @(negedge ref_clk_in);
        b[i] = kline_in;
      end
      repeat (cyc) @(negedge ref_clk_in);
      if (kline_in !== 1'b1)
        b = 8'hxx;
    end
  endtask
endmodule
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the control unit end of the diagnostic line pair.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dlr_pkg::*;
  localparam int SLOW = 20;
  localparam int FAST = 8;
  logic       ref_clk_in;
  logic       srst_in;
  logic       two_wire_in;
  logic       other_tx_in;
  logic       resp_req_in;
  logic [7:0] resp_data_in;
  logic       kline;
  logic       t_k;
  logic       t_l;
  logic       kline_out;
  logic       kline_oe_out;
  logic       online_out;
  logic       resp_done_out;
  dlr_state_t state_out;
  logic       oe_seen;
  int         done_cnt;
  int         miscompares;
  int         compares;
  logic [7:0] got;

  // Open-drain data line with pull-up: low if either party pulls it down.
  // Shared data line
  assign kline = t_k & (kline_oe_out ? kline_out : 1'b1);

  dlr_ctrl #(.SLOW_BIT_CYC(32'h14), .SLOT_CYC(32'h28)) uut
  (
    .ref_clk_in     (ref_clk_in),
    .srst_in        (srst_in),
    .two_wire_in    (two_wire_in),
    .my_addr_in     (8'h33),
    .fast_bit_cyc_in(32'h8),
    .kline_in       (kline),
    .lline_in       (t_l),
    .other_tx_in    (other_tx_in),
    .resp_req_in    (resp_req_in),
    .resp_data_in   (resp_data_in),
    .kline_out      (kline_out),
    .kline_oe_out   (kline_oe_out),
    .online_out     (online_out),
    .resp_done_out  (resp_done_out),
    .state_out      (state_out)
  );

  dlr_tester tst
  (
    .ref_clk_in(ref_clk_in),
    .kline_in  (kline),
    .kline_out (t_k),
    .lline_out (t_l)
  );

  // Free-running 100 MHz clock.
  initial
  begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  // Notes any drive of the data line and counts frame-done pulses, away from the launching edge.
  always @(negedge ref_clk_in)
  begin
    if (kline_oe_out === 1'b1)
      oe_seen <= 1'b1;
    if (resp_done_out === 1'b1)
      done_cnt <= done_cnt + 1;
  end

  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic end_of_test();
    if (miscompares == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic quiet(input int n);
    oe_seen = 1'b0;
    repeat (n) @(negedge ref_clk_in);
    chk("idle_oe", 8'h0, {7'h0, oe_seen});
    chk("state", {4'h0, DLR_IDLE}, {4'h0, state_out});
  endtask

  task automatic do_reset();
    @(negedge ref_clk_in);
    srst_in = 1'b1;
    repeat (10) @(negedge ref_clk_in);
    srst_in = 1'b0;
    @(negedge ref_clk_in);
    chk("rst_oe", 8'h0, {7'h0, kline_oe_out});
    chk("rst_online", 8'h0, {7'h0, online_out});
  endtask

  // An address meant for another unit leaves this one silent.
  task automatic t_wrong_addr();
    two_wire_in = 1'b1;
    tst.send(8'h32, SLOW, 1);
    quiet(300);
  endtask

  // An address frame seen while another unit talks never starts a wake-up.
  task automatic t_cross();
    other_tx_in = 1'b1;
    tst.send(8'h33, SLOW, 1);
    quiet(300);
    other_tx_in = 1'b0;
  endtask

  // Wake-up: address, sync, two keys, handshake, then inverted address, or silence after a wrong handshake.
  task automatic t_init(input logic two, input int lmode, input logic [7:0] hs);
    two_wire_in = two;
    tst.send(8'h33, SLOW, lmode);
    tst.recv(FAST, got);
    chk("sync", 8'h55, got);
    tst.recv(FAST, got);
    chk("key1", 8'h94, got);
    tst.recv(FAST, got);
    chk("key2", 8'h94, got);
    repeat (2 * FAST) @(negedge ref_clk_in);
    tst.send(hs, FAST, 0);
    if (hs == 8'h6b)
    begin
      tst.recv(FAST, got);
      chk("inv_addr", 8'hcc, got);
      @(negedge ref_clk_in);
      chk("online", 8'h1, {7'h0, online_out});
    end
    else
      quiet(400);
  endtask

  // A response waits while another unit talks, then goes out once.
  // The wait at the top lets the done pulse of the inverted address pass before counting.
  task automatic t_resp();
    repeat (4) @(negedge ref_clk_in);
    other_tx_in = 1'b1;
    resp_req_in = 1'b1;
    resp_data_in = 8'ha6;
    oe_seen = 1'b0;
    done_cnt = 0;
    repeat (50) @(negedge ref_clk_in);
    chk("blocked_oe", 8'h0, {7'h0, oe_seen});
    other_tx_in = 1'b0;
    tst.recv(FAST, got);
    @(negedge ref_clk_in);
    resp_req_in = 1'b0;
    repeat (2 * FAST) @(negedge ref_clk_in);
    chk("resp", 8'ha6, got);
    chk("done_cnt", 8'h1, done_cnt[7:0]);
    chk("after_oe", 8'h0, {7'h0, kline_oe_out});
  endtask

  initial
  begin
    srst_in = 1'b1;
    two_wire_in = 1'b1;
    other_tx_in = 1'b0;
    resp_req_in = 1'b0;
    resp_data_in = 8'h00;
    oe_seen = 1'b0;
    done_cnt = 0;
    miscompares = 0;
    compares = 0;
    do_reset();
    t_wrong_addr();
    t_cross();
    t_init(1'b1, 1, 8'h6b);
    t_resp();
    do_reset();
    t_init(1'b0, 2, 8'h6b);
    do_reset();
    t_init(1'b1, 1, 8'h6a);
    end_of_test();
  end

  // Cuts a hang short well beyond the few thousand cycles the run needs.
  initial
  begin
    repeat (20000) @(posedge ref_clk_in);
    miscompares++;
    end_of_test();
  end
endmodule
`default_nettype wire
